// ### logic/wake_pin_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module wake_pin_monitor
  import wake_pin_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic wake_input_in,
  input wire chip_mode_t chip_mode_in,
  input wire logic undervoltage_off_in,
  input wire logic wake_input_enable_in,
  input wire logic mask_rise_in,
  input wire logic mask_fall_in,
  input wire logic clear_flag_a_in,
  input wire logic clear_flag_b_in,
  output logic wake_level_status_out,
  output logic wake_edge_flag_a_out,
  output logic wake_edge_flag_b_out,
  output logic irq_out,
  output logic wake_request_out,
  output logic restart_request_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic level_stat;
    logic flag_a;
    logic flag_b;
    logic irq;
    logic wake_req;
    logic restart_req;
  } mon_state_t;

  mon_state_t s_q;
  mon_state_t s_d;
  logic filt_level;
  logic filt_rise;
  logic filt_fall;

  function automatic logic awake_mode(input chip_mode_t m);
    awake_mode = (m == MODE_NORMAL) || (m == MODE_STOP) || (m == MODE_SW_UPDATE);
  endfunction

  wake_glitch_filter u_filter (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .raw_in(wake_input_in),
    .level_out(filt_level),
    .rise_out(filt_rise),
    .fall_out(filt_fall)
  );

  // ----------------------------------------
  // Flags and wake decisions
  // ----------------------------------------
  logic edge_any;
  logic powered;
  assign powered = !(undervoltage_off_in || chip_mode_in == MODE_OFF);
  assign edge_any = (filt_rise || filt_fall) && powered;
  logic flag_arm;
  assign flag_arm = awake_mode(chip_mode_in) && wake_input_enable_in && powered;

  always_comb begin
    s_d = s_q;
    if (awake_mode(chip_mode_in)) begin
      s_d.level_stat = filt_level;
    end
    // Clear first, a same-cycle edge wins
    if (clear_flag_a_in) begin
      s_d.flag_a = 1'b0;
    end
    if (clear_flag_b_in) begin
      s_d.flag_b = 1'b0;
    end
    if (awake_mode(chip_mode_in) && wake_input_enable_in && powered) begin
      if (filt_rise) begin
        s_d.flag_a = 1'b1;
      end
      if (filt_fall) begin
        s_d.flag_b = 1'b1;
      end
    end
    s_d.irq = (s_d.flag_a && !mask_rise_in) || (s_d.flag_b && !mask_fall_in);
    // Sleep exit: qualified edge or a pending flag
    s_d.wake_req = (chip_mode_in == MODE_SLEEP) && powered &&
      ((wake_input_enable_in && edge_any) || s_q.flag_a || s_q.flag_b);
    s_d.restart_req = (chip_mode_in == MODE_FAILSAFE) && edge_any;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wake_level_status_out = s_q.level_stat;
  assign wake_edge_flag_a_out = s_q.flag_a;
  assign wake_edge_flag_b_out = s_q.flag_b;
  assign irq_out = s_q.irq;
  assign wake_request_out = s_q.wake_req;
  assign restart_request_out = s_q.restart_req;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  flag_rise_set_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (filt_rise && powered && wake_input_enable_in && awake_mode(chip_mode_in))
    |=> wake_edge_flag_a_out)
    else $error("rising edge did not set flag a");
  flag_fall_set_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (filt_fall && powered && wake_input_enable_in && awake_mode(chip_mode_in))
    |=> wake_edge_flag_b_out)
    else $error("falling edge did not set flag b");
  flag_origin_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(wake_edge_flag_a_out) |-> $past(filt_rise && flag_arm))
    else $error("flag a rose without qualified edge");
  flag_origin_b_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(wake_edge_flag_b_out) |-> $past(filt_fall && flag_arm))
    else $error("flag b rose without qualified edge");
  flag_sticky_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (wake_edge_flag_a_out && !clear_flag_a_in) |=> wake_edge_flag_a_out)
    else $error("flag a dropped without clear");
  flag_sticky_b_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (wake_edge_flag_b_out && !clear_flag_b_in) |=> wake_edge_flag_b_out)
    else $error("flag b dropped without clear");
  clear_a_done_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (clear_flag_a_in && !(filt_rise && flag_arm)) |=> !wake_edge_flag_a_out)
    else $error("flag a not cleared");
  clear_b_done_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (clear_flag_b_in && !(filt_fall && flag_arm)) |=> !wake_edge_flag_b_out)
    else $error("flag b not cleared");
  enable_gate_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (!wake_input_enable_in && !wake_edge_flag_b_out && !clear_flag_b_in)
    |=> !wake_edge_flag_b_out)
    else $error("flag b set while disabled");
  rise_enable_gate_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (!wake_input_enable_in && !wake_edge_flag_a_out) |=> !wake_edge_flag_a_out)
    else $error("flag a set while disabled");
  off_ignore_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    undervoltage_off_in |=> !wake_request_out && !restart_request_out)
    else $error("wake acted on while off");
  off_mode_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (chip_mode_in == MODE_OFF) |=> !wake_request_out && !restart_request_out)
    else $error("wake acted on in off state");
  unpowered_flags_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (!powered && !wake_edge_flag_a_out && !wake_edge_flag_b_out)
    |=> !wake_edge_flag_a_out && !wake_edge_flag_b_out)
    else $error("flag set while unpowered");
  level_report_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    awake_mode(chip_mode_in) |=> wake_level_status_out == $past(filt_level))
    else $error("level status stale");
  level_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !awake_mode(chip_mode_in) |=> $stable(wake_level_status_out))
    else $error("level status moved outside awake modes");

  // ----------------------------------------
  // Sleep and restart checks
  // ----------------------------------------
  sleep_wake_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (chip_mode_in == MODE_SLEEP && !undervoltage_off_in &&
     (wake_edge_flag_a_out || wake_edge_flag_b_out)) |=> wake_request_out)
    else $error("sleep kept with pending flag");
  sleep_edge_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (chip_mode_in == MODE_SLEEP && wake_input_enable_in && edge_any) |=> wake_request_out)
    else $error("enabled edge did not leave sleep");
  sleep_disabled_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (chip_mode_in == MODE_SLEEP && !wake_input_enable_in &&
     !wake_edge_flag_a_out && !wake_edge_flag_b_out) |=> !wake_request_out)
    else $error("disabled pin woke the chip");
  awake_no_wake_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (chip_mode_in != MODE_SLEEP) |=> !wake_request_out)
    else $error("wake request outside sleep");
  failsafe_edge_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (chip_mode_in == MODE_FAILSAFE && edge_any) |=> restart_request_out)
    else $error("fail-safe edge ignored");
  restart_only_fs_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !(chip_mode_in == MODE_FAILSAFE && edge_any) |=> !restart_request_out)
    else $error("restart request without fail-safe edge");
  restart_pulse_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    restart_request_out |=> !restart_request_out)
    else $error("restart request longer than one cycle");

  // ----------------------------------------
  // Interrupt checks
  // ----------------------------------------
  irq_mask_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (mask_rise_in && mask_fall_in) |=> !irq_out)
    else $error("interrupt despite masks");
  irq_source_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    irq_out |-> (wake_edge_flag_a_out || wake_edge_flag_b_out))
    else $error("interrupt without flag");
  irq_follow_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    1'b1 |=> irq_out == ((wake_edge_flag_a_out && !$past(mask_rise_in)) ||
      (wake_edge_flag_b_out && !$past(mask_fall_in))))
    else $error("interrupt does not follow flags and masks");

  // ----------------------------------------
  // Covers
  // ----------------------------------------
  wake_sleep_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    chip_mode_in == MODE_SLEEP && wake_request_out);
  flag_irq_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    irq_out && wake_edge_flag_a_out);
  restart_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    restart_request_out);
  pending_sleep_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    chip_mode_in == MODE_SLEEP && wake_edge_flag_b_out);
  masked_flag_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    wake_edge_flag_a_out && !irq_out);
endmodule
`default_nettype wire

// ### logic/wake_pin_pkg.sv
`default_nettype none
package wake_pin_pkg;
  // Chip modes as seen by this block
  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FAILSAFE,
    MODE_SW_UPDATE
  } chip_mode_t;

  localparam int unsigned CLK_FREQ_HZ = 20000000;
  localparam int unsigned FILTER_MIN_US = 10;
  localparam int unsigned FILTER_MAX_US = 25;
  localparam int unsigned FILTER_MIN_CYC = (FILTER_MIN_US * (CLK_FREQ_HZ / 1000000));
  localparam int unsigned FILTER_MAX_CYC = (FILTER_MAX_US * (CLK_FREQ_HZ / 1000000));
  // Pick the middle of the window
  localparam int unsigned FILTER_CYC = (FILTER_MIN_CYC + FILTER_MAX_CYC) / 2;
  localparam int unsigned FILT_W = 10;
  localparam logic [FILT_W-1:0] FILTER_LIMIT = FILT_W'(FILTER_CYC);
  localparam logic RESET_LEVEL = 1'b0;
  localparam logic RESET_ENABLE = 1'b0;
endpackage
`default_nettype wire

// ### logic/wake_glitch_filter.sv
`timescale 1ns/10ps
`default_nettype none
module wake_glitch_filter
  import wake_pin_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic raw_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  typedef struct packed {
    logic [2:0] sync;
    logic cand;
    logic [FILT_W-1:0] cnt;
    logic level;
    logic rise;
    logic fall;
  } filt_state_t;

  filt_state_t s_q;
  filt_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.sync = {s_q.sync[1:0], raw_in};
    s_d.rise = 1'b0;
    s_d.fall = 1'b0;
    // Second and third stages agree before the level counts
    if (s_q.sync[2] == s_q.sync[1]) begin
      if (s_q.sync[2] != s_q.cand) begin
        s_d.cand = s_q.sync[2];
        s_d.cnt = '0;
      end else if (s_q.cand != s_q.level) begin
        if (s_q.cnt >= FILTER_LIMIT - FILT_W'(1)) begin
          s_d.level = s_q.cand;
          s_d.rise = s_q.cand;
          s_d.fall = ~s_q.cand;
          s_d.cnt = '0;
        end else begin
          s_d.cnt = s_q.cnt + FILT_W'(1);
        end
      end else begin
        s_d.cnt = '0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.level;
  assign rise_out = s_q.rise;
  assign fall_out = s_q.fall;

  filter_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $changed(s_q.level) |-> $past(s_q.cand == s_q.level, 1) == 1'b0)
    else $error("level changed without stable candidate");
  filter_edge_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (rise_out || fall_out) |-> $changed(level_out))
    else $error("edge pulse without level change");
endmodule
`default_nettype wire

// ### dv/wake_source_model.sv
`timescale 1ns/10ps
`default_nettype none
module wake_source_model (
  input wire logic clk_sys_in,
  output logic wake_pin_out
);
  initial wake_pin_out = 1'b0;
  // ----------------------------------------
  // Level change and short disturbance
  // ----------------------------------------
  task automatic set_level(input logic lvl);
    @(negedge clk_sys_in);
    wake_pin_out = lvl;
  endtask
  task automatic glitch(input int n);
    @(negedge clk_sys_in);
    wake_pin_out = ~wake_pin_out;
    repeat (n) @(negedge clk_sys_in);
    wake_pin_out = ~wake_pin_out;
  endtask
endmodule
`default_nettype wire

// ### dv/wake_pin_monitor_bench.sv
`timescale 1ns/10ps
`default_nettype none
module wake_pin_monitor_bench;
  import wake_pin_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic pin;
  logic uv = 1'b0, en = 1'b1, mrise = 1'b0, mfall = 1'b0, ca = 1'b0, cb = 1'b0;
  logic lvl, fa, fb, irq, wreq, rreq;
  chip_mode_t mode = MODE_NORMAL;
  chip_mode_t modes [3] = '{MODE_NORMAL, MODE_STOP, MODE_SW_UPDATE};
  int checks = 0, miscompares = 0, n_wake = 0, n_rst = 0;
  int w0 = 0, r0 = 0;
  always #25 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    if (wreq === 1'b1) n_wake++;
    if (rreq === 1'b1) n_rst++;
  end
  wake_source_model i_src (.clk_sys_in(clk_sys_in), .wake_pin_out(pin));
  wake_pin_monitor i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .wake_input_in(pin),
    .chip_mode_in(mode), .undervoltage_off_in(uv), .wake_input_enable_in(en),
    .mask_rise_in(mrise), .mask_fall_in(mfall), .clear_flag_a_in(ca), .clear_flag_b_in(cb),
    .wake_level_status_out(lvl), .wake_edge_flag_a_out(fa), .wake_edge_flag_b_out(fb),
    .irq_out(irq), .wake_request_out(wreq), .restart_request_out(rreq));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic step(input logic v);
    i_src.set_level(v);
    repeat (380) @(negedge clk_sys_in);
  endtask
  task automatic clr();
    ca = 1'b1;
    cb = 1'b1;
    @(negedge clk_sys_in);
    ca = 1'b0;
    cb = 1'b0;
    repeat (2) @(negedge clk_sys_in);
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    miscompares++;
    print_verdict();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    chk({fa, fb, irq, wreq}, 4'h0);
    for (int i = 0; i < 3; i++) begin
      mode = modes[i];
      step(i != 1);
      chk({lvl, fa, fb, irq}, (i == 1) ? 4'h3 : 4'hD);
      clr();
      chk({fa, fb, irq, rreq}, 4'h0);
    end
    i_src.glitch(340);
    repeat (380) @(negedge clk_sys_in);
    chk({lvl, fa, fb, irq}, 4'h8);
    mrise = 1'b1;
    step(1'b0);
    chk({lvl, fa, fb, irq}, 4'h3);
    clr();
    step(1'b1);
    chk({lvl, fa, fb, irq}, 4'hC);
    mrise = 1'b0;
    mfall = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    chk({lvl, fa, fb, irq}, 4'hD);
    mfall = 1'b0;
    clr();
    en = 1'b0;
    step(1'b0);
    chk({lvl, fa, fb, irq}, 4'h0);
    en = 1'b1;
    mode = MODE_SLEEP;
    w0 = n_wake;
    step(1'b1);
    chk({n_wake != w0, fa, fb, lvl}, 4'h8);
    mode = MODE_NORMAL;
    step(1'b0);
    mode = MODE_SLEEP;
    repeat (3) @(negedge clk_sys_in);
    chk({wreq, fb}, 4'h3);
    clr();
    chk({wreq, fb}, 4'h0);
    en = 1'b0;
    w0 = n_wake;
    step(1'b1);
    chk({1'b0, n_wake != w0, fa, fb}, 4'h0);
    mode = MODE_FAILSAFE;
    r0 = n_rst;
    step(1'b0);
    chk(4'(n_rst - r0), 4'h1);
    mode = MODE_OFF;
    uv = 1'b1;
    en = 1'b1;
    w0 = n_wake;
    r0 = n_rst;
    step(1'b1);
    chk({n_wake != w0, n_rst != r0, fa, fb}, 4'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
